/* File: pdc_cfg_if.sv */
`default_nettype none
interface pdc_cfg_if;
  logic [2:0] row_settle_sel;
  logic [1:0] row_blank_width_sel;
  logic pol_timing;
  logic invert;
  logic pix_pair;
  logic wide;
  logic clk_edge;
  logic clk_blank;
  logic dual_edge;
  logic clk_timing;
  logic strobe_wide;
  logic strobe_pol;
  logic mirror;
  logic scale;
  logic run;
  logic out_en;
  modport src (output row_settle_sel, row_blank_width_sel, pol_timing, invert, pix_pair, wide, clk_edge,
    clk_blank, dual_edge, clk_timing, strobe_wide, strobe_pol, mirror, scale, run, out_en);
  modport snk (input row_settle_sel, row_blank_width_sel, pol_timing, invert, pix_pair, wide, clk_edge,
    clk_blank, dual_edge, clk_timing, strobe_wide, strobe_pol, mirror, scale, run, out_en);
endinterface
`default_nettype wire

/* File: pdc_cfg_sync.sv */
`default_nettype none
module pdc_cfg_sync import pdc_pkg::*; (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire pdc_raw_type raw,
  pdc_cfg_if.src cfg
);
  pdc_raw_type s1_ff;
  pdc_raw_type s2_ff;

  // Two-stage capture; a mid-frame change may still tear one frame
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff <= RAW_RST;
      s2_ff <= RAW_RST;
    end else begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
    end
  end

  // Wide mode overrides most programming straps; settle, blank width, clock blanking, strobe polarity and scale pass through
  assign cfg.row_settle_sel = s2_ff.row_settle_sel;
  assign cfg.row_blank_width_sel = s2_ff.row_blank_width_sel;
  assign cfg.wide = s2_ff.wide;
  assign cfg.pol_timing = s2_ff.wide ? WIDE_POL_TIMING : s2_ff.pol_timing;
  assign cfg.invert = s2_ff.wide ? WIDE_INVERT : s2_ff.invert;
  assign cfg.pix_pair = s2_ff.wide ? WIDE_PIX_PAIR : s2_ff.pix_pair;
  assign cfg.clk_edge = s2_ff.wide ? WIDE_CLK_EDGE : s2_ff.clk_edge;
  assign cfg.dual_edge = s2_ff.wide ? WIDE_DUAL : s2_ff.dual_edge;
  assign cfg.clk_timing = s2_ff.wide ? WIDE_CLK_TIMING : s2_ff.clk_timing;
  assign cfg.strobe_wide = s2_ff.wide ? WIDE_STROBE_W : s2_ff.strobe_wide;
  assign cfg.mirror = s2_ff.wide ? WIDE_MIRROR : s2_ff.mirror;
  assign cfg.clk_blank = s2_ff.clk_blank;
  assign cfg.strobe_pol = s2_ff.strobe_pol;
  assign cfg.scale = s2_ff.scale;
  assign cfg.run = s2_ff.chip_awake;
  assign cfg.out_en = s2_ff.out_awake;

  a_wide_forced: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(s2_ff.wide) |=> cfg.invert && cfg.pix_pair && !cfg.pol_timing && !cfg.mirror && !cfg.dual_edge)
    else $error("wide mode did not force strap values");
endmodule // pdc_cfg_sync
`default_nettype wire

/* File: pdc_panel_model.sv */
`default_nettype none
module pdc_panel_model import pdc_pkg::*; (
  input wire logic clk_sys,
  input wire logic [BUS_W-1:0] column_pixel_bus,
  input wire logic column_clock,
  input wire logic act_level,
  input wire logic dual,
  input wire logic row_blank,
  output logic lat_stb,
  output logic [BUS_W-1:0] lat_dat,
  output logic rows_on
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_ff;
  // Column driver latch; every edge counts in dual mode, so idle flips must be kept out of traffic
  always @(posedge clk_sys) begin
    prev_ff <= column_clock;
    lat_stb <= (column_clock !== prev_ff) && (dual || column_clock === act_level);
    lat_dat <= column_pixel_bus;
  end
  // Row outputs held low while blanked
  assign rows_on = !row_blank;
endmodule // pdc_panel_model
`default_nettype wire

/* File: pdc_pkg.sv */
`default_nettype none
package pdc_pkg;
  // Clock rate and preset timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int ROW_SETTLE_UNIT_NS = 40;
  localparam int ROW_SETTLE_CYC = (ROW_SETTLE_UNIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ROW_CLK_NS = 50;
  localparam int ROW_CLK_CYC = (ROW_CLK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ROW_BLANK_UNIT_NS = 200;
  localparam int ROW_BLANK_CYC = (ROW_BLANK_UNIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STROBE_MIN_NS = 100;
  localparam int STROBE_MIN_CYC = (STROBE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STROBE_MAX_NS = 400;
  localparam int STROBE_MAX_CYC = (STROBE_MAX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SYNC_LOSS_US = 100;
  localparam int SYNC_LOSS_CYC_DEF = SYNC_LOSS_US * 1000 * 1000 / CLK_PERIOD_PS;
  localparam int CNT_W = 10;
  localparam int SYNC_CNT_W = 16;
  // Column clock phases inside a four-cycle word slot
  localparam logic [1:0] CK_LOAD_PH = 2'h0;
  localparam logic [1:0] CK_EDGE_SYM = 2'h2;
  localparam logic [1:0] CK_EDGE_HOLD = 2'h1;
  localparam logic [1:0] CK_RET_OFS = 2'h2;
  // Data path widths and inversion masks
  localparam int PIX_W = 24;
  localparam int NARROW_W = 18;
  localparam int BUS_W = 48;
  localparam logic [47:0] MASK_1PIX = 48'h0000_00ff_ffff;
  localparam logic [47:0] MASK_36 = 48'h000f_ffff_ffff;
  localparam logic [47:0] MASK_48 = 48'hffff_ffff_ffff;
  // Values forced while wide output is selected
  localparam logic WIDE_POL_TIMING = 1'h0;
  localparam logic WIDE_INVERT = 1'h1;
  localparam logic WIDE_PIX_PAIR = 1'h1;
  localparam logic WIDE_CLK_EDGE = 1'h0;
  localparam logic WIDE_DUAL = 1'h0;
  localparam logic WIDE_CLK_TIMING = 1'h0;
  localparam logic WIDE_STROBE_W = 1'h0;
  localparam logic WIDE_MIRROR = 1'h0;
  typedef enum logic [1:0] {
    LN_IDLE = 2'b00,
    LN_SETTLE = 2'b01,
    LN_STROBE = 2'b10,
    LN_POST = 2'b11
  } pdc_line_type;
  typedef struct packed {
    logic [2:0] row_settle_sel;
    logic [1:0] row_blank_width_sel;
    logic pol_timing;
    logic invert;
    logic pix_pair;
    logic wide;
    logic clk_edge;
    logic clk_blank;
    logic dual_edge;
    logic clk_timing;
    logic strobe_wide;
    logic strobe_pol;
    logic mirror;
    logic scale;
    logic chip_awake;
    logic out_awake;
  } pdc_raw_type;
  localparam pdc_raw_type RAW_RST = '0;
endpackage
`default_nettype wire

/* File: pdc_sync_detect.sv */
`default_nettype none
module pdc_sync_detect import pdc_pkg::*; #(
  parameter int unsigned LOSS_CYC = SYNC_LOSS_CYC_DEF
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic hs_edge,
  output logic sync_present
);
  logic [SYNC_CNT_W-1:0] idle_cnt_ff;
  logic present_ff;
  logic timeout;

  assign timeout = idle_cnt_ff == SYNC_CNT_W'(LOSS_CYC - 1);
  assign sync_present = present_ff;

  // Runs even in chip sleep so the link can still be watched
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      idle_cnt_ff <= '0;
      present_ff <= 1'b0;
    end else if (hs_edge) begin
      idle_cnt_ff <= '0;
      present_ff <= 1'b1;
    end else if (timeout) begin
      present_ff <= 1'b0;
    end else begin
      idle_cnt_ff <= idle_cnt_ff + SYNC_CNT_W'(1);
    end
  end

  a_sync_seen: assert property (@(posedge clk_sys) disable iff (!arst_n)
    hs_edge |=> sync_present)
    else $error("sync present not raised by hsync");
  a_sync_lost: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (timeout && !hs_edge) |=> !sync_present && $stable(idle_cnt_ff))
    else $error("sync present not dropped after timeout");
endmodule // pdc_sync_detect
`default_nettype wire

/* File: pdc_top.sv */
`default_nettype none
module pdc_top import pdc_pkg::*; #(
  parameter int unsigned SYNC_LOSS_CYC = SYNC_LOSS_CYC_DEF
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [2:0] row_settle_sel,
  input wire logic [1:0] row_blank_width_sel,
  input wire logic polarity_toggle_timing,
  input wire logic data_invert_sel,
  input wire logic pixel_count_sel,
  input wire logic wide_output_sel,
  input wire logic column_clock_edge_sel,
  input wire logic column_clock_blank_en,
  input wire logic dual_edge_sel,
  input wire logic column_clock_timing_sel,
  input wire logic strobe_width_sel,
  input wire logic strobe_polarity_sel,
  input wire logic mirror_enable,
  input wire logic timing_scale,
  input wire logic chip_sleep_n,
  input wire logic output_sleep_n,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic scan_direction_in,
  input wire logic pix_valid,
  input wire logic [PIX_W-1:0] pix_data,
  output logic sync_present,
  output logic [BUS_W-1:0] column_pixel_bus,
  output logic column_clock,
  output logic column_start_bit,
  output logic column_start_bit_oe,
  output logic alt_column_start_bit,
  output logic alt_column_start_bit_oe,
  output logic transfer_strobe,
  output logic row_clock,
  output logic row_start_bit,
  output logic row_blank,
  output logic lc_polarity_out,
  output logic lc_polarity_n_out,
  output logic scan_direction_select
);
  pdc_cfg_if cfg ();
  pdc_raw_type raw;

  // Line sequencer
  pdc_line_type line_st_ff;
  pdc_line_type nxt_line_st;
  logic [CNT_W-1:0] line_cnt_ff;
  logic [CNT_W-1:0] nxt_line_cnt;
  logic pol_ff;
  logic pol_flip;
  logic hs_prev_ff;
  logic vs_prev_ff;
  logic hs_rise;
  logic vs_rise;
  logic [CNT_W-1:0] settle_len;
  logic [CNT_W-1:0] blank_len;
  logic [CNT_W-1:0] strobe_len;
  logic cnt_last;
  // Row outputs
  logic [CNT_W-1:0] rclk_cnt_ff;
  logic [CNT_W-1:0] nxt_rclk_cnt;
  logic [CNT_W-1:0] rblank_cnt_ff;
  logic [CNT_W-1:0] nxt_rblank_cnt;
  logic rstart_pend_ff;
  logic rstart_ff;
  logic nxt_rstart;
  // Column path
  logic [1:0] ph_ff;
  logic pair_ph_ff;
  logic nxt_pair_ph;
  logic [PIX_W-1:0] pix_hold_ff;
  logic [BUS_W-1:0] word_ff;
  logic [BUS_W-1:0] new_word;
  logic [BUS_W-1:0] inv_mask;
  logic word_pend_ff;
  logic word_done;
  logic load;
  logic slot_ff;
  logic nxt_slot;
  logic first_pend_ff;
  logic cin_act_ff;
  logic nxt_cin_act;
  logic cck_ff;
  logic nxt_cck;
  logic [1:0] edge_ph;
  logic [1:0] ret_ph;
  logic pulse_ok;
  logic dir;
  logic awake;
  // Output flops
  logic [BUS_W-1:0] bus_ff;
  logic cck_out_ff;
  logic cin_ff;
  logic cin_oe_ff;
  logic alt_column_start_bit_ff;
  logic alt_column_start_bit_oe_ff;
  logic strobe_ff;
  logic rclk_out_ff;
  logic rstart_out_ff;
  logic rblank_out_ff;
  logic pol_out_ff;
  logic pol_n_out_ff;
  logic dir_out_ff;

  // Doubles a preset when the timing scale strap is set
  function automatic logic [CNT_W-1:0] f_scale(input logic [CNT_W-1:0] base, input logic dbl);
    f_scale = dbl ? {base[CNT_W-2:0], 1'b0} : base;
  endfunction

  // Keeps the top six bits of each colour for the 36-bit path
  function automatic logic [NARROW_W-1:0] f_pack18(input logic [PIX_W-1:0] p);
    f_pack18 = {p[23:18], p[15:10], p[7:2]};
  endfunction

  assign raw = {row_settle_sel, row_blank_width_sel, polarity_toggle_timing, data_invert_sel,
    pixel_count_sel, wide_output_sel, column_clock_edge_sel, column_clock_blank_en, dual_edge_sel,
    column_clock_timing_sel, strobe_width_sel, strobe_polarity_sel, mirror_enable, timing_scale,
    chip_sleep_n, output_sleep_n};

  pdc_cfg_sync u_cfg (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .raw(raw),
    .cfg(cfg)
  );

  pdc_sync_detect #(
    .LOSS_CYC(SYNC_LOSS_CYC)
  ) u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .hs_edge(hs_rise),
    .sync_present(sync_present)
  );

  // Edge detection and preset lengths
  assign hs_rise = hsync_in & ~hs_prev_ff;
  assign vs_rise = vsync_in & ~vs_prev_ff;
  assign settle_len = f_scale(CNT_W'((int'(cfg.row_settle_sel) + 1) * ROW_SETTLE_CYC), cfg.scale);
  assign blank_len = f_scale(CNT_W'((int'(cfg.row_blank_width_sel) + 1) * ROW_BLANK_CYC), cfg.scale);
  assign strobe_len = f_scale(cfg.strobe_wide ? CNT_W'(STROBE_MAX_CYC) : CNT_W'(STROBE_MIN_CYC), cfg.scale);
  assign cnt_last = line_cnt_ff == CNT_W'(1);
  assign awake = cfg.run & cfg.out_en;

  // Row clock, blank pulse and start bit
  assign nxt_rclk_cnt = hs_rise ? CNT_W'(ROW_CLK_CYC) : (rclk_cnt_ff != '0) ? rclk_cnt_ff - CNT_W'(1) : rclk_cnt_ff;
  assign nxt_rblank_cnt = hs_rise ? blank_len : (rblank_cnt_ff != '0) ? rblank_cnt_ff - CNT_W'(1) : rblank_cnt_ff;
  assign nxt_rstart = hs_rise ? (rstart_pend_ff | vs_rise) : (rstart_ff & (rclk_cnt_ff != CNT_W'(1)));

  // Line sequence: settle after the row clock, then the strobe
  always_comb begin
    nxt_line_st = line_st_ff;
    nxt_line_cnt = line_cnt_ff;
    pol_flip = 1'b0;
    if (hs_rise) begin
      nxt_line_st = LN_SETTLE;
      nxt_line_cnt = settle_len;
    end else begin
      case (line_st_ff)
        LN_SETTLE: begin
          nxt_line_cnt = line_cnt_ff - CNT_W'(1);
          if (cnt_last) begin
            nxt_line_st = LN_STROBE;
            nxt_line_cnt = strobe_len;
            pol_flip = ~cfg.pol_timing;
          end
        end
        LN_STROBE: begin
          nxt_line_cnt = line_cnt_ff - CNT_W'(1);
          if (cnt_last) begin
            nxt_line_st = LN_POST;
          end
        end
        LN_POST: begin
          nxt_line_st = LN_IDLE;
          pol_flip = cfg.pol_timing;
        end
        default: begin
          nxt_line_st = line_st_ff;
        end
      endcase
    end
  end

  // Word assembly; inversion covers only the bits the mode drives
  assign word_done = pix_valid & (~cfg.pix_pair | pair_ph_ff);
  assign nxt_pair_ph = hs_rise ? 1'b0 : word_done ? 1'b0 : (pix_valid & cfg.pix_pair) ? 1'b1 : pair_ph_ff;
  assign new_word = ~cfg.pix_pair ? {24'h00_0000, pix_data} :
    cfg.wide ? {pix_data, pix_hold_ff} : {12'h000, f_pack18(pix_data), f_pack18(pix_hold_ff)};
  assign inv_mask = ~cfg.invert ? 48'h0000_0000_0000 : ~cfg.pix_pair ? MASK_1PIX :
    cfg.wide ? MASK_48 : MASK_36;
  assign load = word_pend_ff & (ph_ff == CK_LOAD_PH);
  assign nxt_slot = (ph_ff == CK_LOAD_PH) ? load : slot_ff;
  assign nxt_cin_act = (ph_ff == CK_LOAD_PH) ? (load & first_pend_ff) : cin_act_ff;

  // Column clock shaping; the hold setting trades setup for hold
  assign edge_ph = cfg.clk_timing ? CK_EDGE_HOLD : CK_EDGE_SYM;
  assign ret_ph = edge_ph + CK_RET_OFS;
  assign pulse_ok = slot_ff | ~cfg.clk_blank;
  assign nxt_cck = cfg.dual_edge ? (((ph_ff == edge_ph) & pulse_ok) ? ~cck_ff : cck_ff) :
    ((ph_ff == edge_ph) & pulse_ok) ? cfg.clk_edge : (ph_ff == ret_ph) ? ~cfg.clk_edge : cck_ff;
  assign dir = cfg.mirror & scan_direction_in;

  // Sync input history; kept running for the sync monitor
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hs_prev_ff <= 1'b0;
      vs_prev_ff <= 1'b0;
    end else begin
      hs_prev_ff <= hsync_in;
      vs_prev_ff <= vsync_in;
    end
  end

  // Line and row state, frozen while the chip sleeps
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      line_st_ff <= LN_IDLE;
      line_cnt_ff <= '0;
      pol_ff <= 1'b0;
      rclk_cnt_ff <= '0;
      rblank_cnt_ff <= '0;
      rstart_pend_ff <= 1'b0;
      rstart_ff <= 1'b0;
    end else if (cfg.run) begin
      line_st_ff <= nxt_line_st;
      line_cnt_ff <= nxt_line_cnt;
      pol_ff <= pol_ff ^ pol_flip;
      rclk_cnt_ff <= nxt_rclk_cnt;
      rblank_cnt_ff <= nxt_rblank_cnt;
      rstart_pend_ff <= vs_rise | (rstart_pend_ff & ~hs_rise);
      rstart_ff <= nxt_rstart;
    end
  end

  // Column state; a new word arriving at load time stays pending
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ph_ff <= 2'h0;
      pair_ph_ff <= 1'b0;
      pix_hold_ff <= '0;
      word_ff <= '0;
      word_pend_ff <= 1'b0;
      slot_ff <= 1'b0;
      first_pend_ff <= 1'b0;
      cin_act_ff <= 1'b0;
      cck_ff <= 1'b0;
    end else if (cfg.run) begin
      ph_ff <= ph_ff + 2'h1;
      pair_ph_ff <= nxt_pair_ph;
      pix_hold_ff <= (pix_valid & ~word_done) ? pix_data : pix_hold_ff;
      word_ff <= word_done ? new_word : word_ff;
      word_pend_ff <= word_done | (word_pend_ff & ~load);
      slot_ff <= nxt_slot;
      first_pend_ff <= hs_rise | (first_pend_ff & ~load);
      cin_act_ff <= nxt_cin_act;
      cck_ff <= nxt_cck;
    end
  end

  // Pin flops; sleep drives every pin low and actively, except both start-bit output enables, which are held high
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bus_ff <= '0;
      cck_out_ff <= 1'b0;
      cin_ff <= 1'b0;
      cin_oe_ff <= 1'b1;
      alt_column_start_bit_ff <= 1'b0;
      alt_column_start_bit_oe_ff <= 1'b1;
      strobe_ff <= 1'b0;
      rclk_out_ff <= 1'b0;
      rstart_out_ff <= 1'b0;
      rblank_out_ff <= 1'b0;
      pol_out_ff <= 1'b0;
      pol_n_out_ff <= 1'b0;
      dir_out_ff <= 1'b0;
    end else if (!awake) begin
      bus_ff <= '0;
      cck_out_ff <= 1'b0;
      cin_ff <= 1'b0;
      cin_oe_ff <= 1'b1;
      alt_column_start_bit_ff <= 1'b0;
      alt_column_start_bit_oe_ff <= 1'b1;
      strobe_ff <= 1'b0;
      rclk_out_ff <= 1'b0;
      rstart_out_ff <= 1'b0;
      rblank_out_ff <= 1'b0;
      pol_out_ff <= 1'b0;
      pol_n_out_ff <= 1'b0;
      dir_out_ff <= 1'b0;
    end else begin
      bus_ff <= load ? (word_ff ^ inv_mask) : bus_ff;
      cck_out_ff <= nxt_cck;
      cin_ff <= nxt_cin_act & ~dir;
      cin_oe_ff <= ~dir;
      alt_column_start_bit_ff <= nxt_cin_act & dir;
      alt_column_start_bit_oe_ff <= ~cfg.mirror | dir;
      strobe_ff <= (nxt_line_st == LN_STROBE) ^ cfg.strobe_pol;
      rclk_out_ff <= nxt_rclk_cnt != '0;
      rstart_out_ff <= nxt_rstart;
      rblank_out_ff <= nxt_rblank_cnt != '0;
      pol_out_ff <= pol_ff ^ pol_flip;
      pol_n_out_ff <= ~(pol_ff ^ pol_flip) & ~cfg.wide;
      dir_out_ff <= cfg.wide ? vsync_in : scan_direction_in;
    end
  end

  assign column_pixel_bus = bus_ff;
  assign column_clock = cck_out_ff;
  assign column_start_bit = cin_ff;
  assign column_start_bit_oe = cin_oe_ff;
  assign alt_column_start_bit = alt_column_start_bit_ff;
  assign alt_column_start_bit_oe = alt_column_start_bit_oe_ff;
  assign transfer_strobe = strobe_ff;
  assign row_clock = rclk_out_ff;
  assign row_start_bit = rstart_out_ff;
  assign row_blank = rblank_out_ff;
  assign lc_polarity_out = pol_out_ff;
  assign lc_polarity_n_out = pol_n_out_ff;
  assign scan_direction_select = dir_out_ff;

  a_settle_min: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (hs_rise && cfg.run && cfg.row_settle_sel == 3'h0 && !cfg.scale) |=>
    (line_st_ff == LN_SETTLE)[*8] ##1 (line_st_ff == LN_STROBE))
    else $error("row settle interval wrong");
  a_blank_load: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (hs_rise && cfg.run) |=> rblank_cnt_ff == $past(blank_len) && (row_blank || !$past(awake)))
    else $error("row blank width not loaded");
  a_pol_before: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cfg.run && !cfg.pol_timing && !hs_rise && line_st_ff == LN_SETTLE && cnt_last) |=>
    pol_ff != $past(pol_ff) && line_st_ff == LN_STROBE)
    else $error("polarity not toggled before strobe");
  a_pol_after: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cfg.run && cfg.pol_timing && !hs_rise && line_st_ff == LN_STROBE && cnt_last) |=>
    pol_ff == $past(pol_ff) ##1 (!$past(cfg.run) || $past(hs_rise) || pol_ff != $past(pol_ff, 2)))
    else $error("polarity not toggled after strobe");
  a_invert_one: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cfg.run && awake && load && cfg.invert && !cfg.pix_pair) |=>
    column_pixel_bus == {24'h00_0000, ~$past(word_ff[23:0])})
    else $error("column data not inverted");
  a_pair_wide: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cfg.run && pix_valid && cfg.pix_pair && pair_ph_ff && cfg.wide) |=>
    word_pend_ff && word_ff == {$past(pix_data), $past(pix_hold_ff)})
    else $error("two-pixel word wrongly formed");
  a_clock_blank: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cfg.run && awake && cfg.clk_blank && !cfg.dual_edge && !slot_ff && ph_ff != CK_LOAD_PH &&
    cck_ff != cfg.clk_edge) |=>
    column_clock == !$past(cfg.clk_edge))
    else $error("column clock pulsed without data");
  a_strobe_pol: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cfg.run && awake && line_st_ff == LN_STROBE && !cnt_last && !hs_rise) |=>
    transfer_strobe != $past(cfg.strobe_pol))
    else $error("strobe polarity wrong");
  a_mirror_oe: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (awake && cfg.mirror) |=> column_start_bit_oe == !$past(scan_direction_in) &&
    alt_column_start_bit_oe == $past(scan_direction_in))
    else $error("mirror start pin enables wrong");
  a_sleep_low: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !awake |=> column_pixel_bus == '0 && !column_clock && !transfer_strobe && !row_clock &&
    !row_blank && !lc_polarity_out && !column_start_bit && !alt_column_start_bit && !scan_direction_select)
    else $error("outputs not low in sleep");
endmodule // pdc_top
`default_nettype wire

/* File: tb_panel_drive_strap_config.sv */
`default_nettype none
module tb_panel_drive_strap_config import pdc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, arst_n = 0, pt = 0, di = 0, pc = 0, wd = 0, ce = 0, de = 0, ct = 0, sw = 0, sp = 0;
  logic me = 0, ts = 0, cs = 1, os = 1, hs = 0, vs = 0, sd = 0, pv = 0, mon = 0, mir, cb = 1;
  logic [2:0] rs = 0;
  logic [1:0] rb = 0;
  logic [23:0] pd = 0, p0, p1;
  logic [47:0] q[$], ex;
  logic [BUS_W-1:0] column_pixel_bus, lat_dat;
  logic sync_present, column_clock, column_start_bit, column_start_bit_oe, alt_column_start_bit;
  logic alt_column_start_bit_oe, transfer_strobe, row_clock, row_start_bit, row_blank, lc_polarity_out;
  logic lc_polarity_n_out, scan_direction_select, lat_stb, rows_on;
  int err_total = 0, n_checks = 0;
  wire logic any_out = |{column_pixel_bus, column_clock, column_start_bit, alt_column_start_bit,
    transfer_strobe, row_clock, row_start_bit, row_blank, lc_polarity_out, scan_direction_select};
  // Mirroring is forced off in wide mode
  assign mir = me & !wd;
  always #2.5 clk_sys = ~clk_sys;
  // Short sync loss limit keeps the run brief
  pdc_top #(.SYNC_LOSS_CYC(50)) i_dut (.clk_sys, .arst_n, .row_settle_sel(rs), .row_blank_width_sel(rb),
    .polarity_toggle_timing(pt), .data_invert_sel(di), .pixel_count_sel(pc), .wide_output_sel(wd),
    .column_clock_edge_sel(ce), .column_clock_blank_en(cb), .dual_edge_sel(de), .column_clock_timing_sel(ct),
    .strobe_width_sel(sw), .strobe_polarity_sel(sp), .mirror_enable(me), .timing_scale(ts), .chip_sleep_n(cs),
    .output_sleep_n(os), .hsync_in(hs), .vsync_in(vs), .scan_direction_in(sd), .pix_valid(pv), .pix_data(pd),
    .sync_present, .column_pixel_bus, .column_clock, .column_start_bit, .column_start_bit_oe,
    .alt_column_start_bit, .alt_column_start_bit_oe, .transfer_strobe, .row_clock, .row_start_bit, .row_blank,
    .lc_polarity_out, .lc_polarity_n_out, .scan_direction_select);
  pdc_panel_model i_drv (.clk_sys, .column_pixel_bus, .column_clock, .act_level(ce & !wd), .dual(de & !wd),
    .row_blank, .lat_stb, .lat_dat, .rows_on);
  task chk(string nm, logic [47:0] s, logic [47:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task print_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [17:0] pk(logic [23:0] v);
    return {v[23:18], v[15:10], v[7:2]};
  endfunction
  // One pixel per word slot; back-to-back words expose a latch on the wrong edge
  task automatic send(logic [23:0] v);
    @(negedge clk_sys);
    pd = v;
    pv = 1;
    @(negedge clk_sys);
    pv = 0;
    repeat (2) @(negedge clk_sys);
  endtask
  // Line timing measured from the row clock rise
  task automatic run_line();
    int r = -1, s = -1, e = -1, b = -1, p = -1, n, k;
    logic lp;
    k = ts ? 2 : 1;
    lp = lc_polarity_out;
    hs = 1;
    for (n = 0; n < 1000 && (b < 0 || e < 0 || p < 0); n++) begin
      @(posedge clk_sys);
      #1;
      if (r < 0 && row_clock) r = n;
      if (s < 0 && (transfer_strobe ^ sp)) s = n;
      if (s >= 0 && e < 0 && !(transfer_strobe ^ sp)) e = n;
      if (p < 0 && lc_polarity_out !== lp) p = n;
      if (r >= 0 && b < 0 && rows_on) b = n;
    end
    if (n >= 1000) begin
      err_total++;
      print_verdict();
    end
    chk("settle", 48'(s - r), 48'((rs + 1) * 8 * k));
    chk("strobe", 48'(e - s), 48'((sw ? 80 : 20) * k));
    chk("blank", 48'(b - r), 48'((rb + 1) * 40 * k));
    chk("polarity", 48'(p), 48'(pt ? e + 1 : s));
    chk("polarity n", lc_polarity_n_out, 48'(lp));
    @(negedge clk_sys);
    hs = 0;
  endtask
  // Every latch by the driver takes the oldest expected word; a latch with none pending is a stray clock
  always @(negedge clk_sys) if (mon && lat_stb) begin
    if (q.size() == 0) chk("extra latch", 48'h1, 48'h0);
    else chk("column word", lat_dat, q.pop_front());
  end
  // Start bit lands on one pin; the other is released only while mirroring
  always @(negedge clk_sys) if (mon && (column_start_bit || alt_column_start_bit)) begin
    chk("start pins", {alt_column_start_bit, column_start_bit}, mir ? (sd ? 48'h2 : 48'h1) : 48'h1);
    chk("start oe", {alt_column_start_bit_oe, column_start_bit_oe}, {!(mir && !sd), !(mir && sd)});
  end
  // Hang guard
  initial begin
    #400000;
    err_total++;
    print_verdict();
  end
  initial begin
    int i, m;
    void'($urandom(35624));
    repeat (20) @(negedge clk_sys);
    arst_n = 1;
    repeat (5) @(negedge clk_sys);
    // Every settle, blank, width, polarity and scale code
    for (i = 0; i < 8; i++) begin
      rs = 3'(i);
      rb = 2'(i);
      {ts, sp, sw} = 3'(i);
      pt = i[0] ^ i[1];
      repeat (5) @(negedge clk_sys);
      run_line();
    end
    {rs, ts, sp, sw} = 6'h0;
    // Data modes; wide mode gets random straps that it must ignore
    for (m = 0; m < 4; m++) begin
      mon = 0;
      {ce, de, ct, sd, me, vs} = 6'($urandom);
      pc = m > 1;
      wd = m == 3;
      di = m == 1 || (m == 3 && ct);
      repeat (12) @(negedge clk_sys);
      mon = 1;
      hs = 1;
      repeat (4) @(negedge clk_sys);
      repeat (2) begin
        p0 = $urandom;
        p1 = $urandom;
        ex = m == 0 ? {24'h0, p0} : m == 1 ? {24'h0, ~p0} : m == 2 ? {12'h0, pk(p1), pk(p0)} : ~{p1, p0};
        q.push_back(ex);
        send(p0);
        if (m > 1) send(p1);
      end
      repeat (12) @(negedge clk_sys);
      chk("words left", 48'(q.size()), 48'h0);
      chk("direction out", scan_direction_select, wd ? vs : sd);
      hs = 0;
    end
    // Sync loss, then both sleep inputs
    mon = 0;
    sp = 1;
    cb = 0;
    m = 0;
    // Blanking off: idle slots must pulse the column clock too
    repeat (60) begin
      @(negedge clk_sys);
      m += !column_clock;
    end
    chk("free clock", 48'(m > 0), 48'h1);
    chk("sync lost", sync_present, 48'h0);
    hs = 1;
    repeat (4) @(negedge clk_sys);
    chk("sync seen", sync_present, 48'h1);
    chk("awake outs", any_out, 48'h1);
    os = 0;
    repeat (4) @(negedge clk_sys);
    chk("output sleep", any_out, 48'h0);
    os = 1;
    repeat (4) @(negedge clk_sys);
    chk("output wake", any_out, 48'h1);
    cs = 0;
    repeat (4) @(negedge clk_sys);
    chk("chip sleep", any_out, 48'h0);
    print_verdict();
  end
endmodule // tb_panel_drive_strap_config
`default_nettype wire
